/* dv/smbus_master_model.sv */
`timescale 1ns/1ns

// ******************
// Write-only master
// ******************
module smbus_master_model
(
  output logic      sclClk,
  output logic      sdaPullLow,
  input  wire logic sdaWire
);
  localparam int HalfNs  = 150;
  localparam int SetupNs = 30;

  initial
  begin
    sclClk     = 1'b1;
    sdaPullLow = 1'b0;
  end

  task automatic half_bit();
    #(HalfNs);
  endtask

  // START, or repeated START from mid-frame
  task automatic start_cond();
    sdaPullLow = 1'b0;
    half_bit();
    sclClk = 1'b1;
    half_bit();
    sdaPullLow = 1'b1;
    half_bit();
    sclClk = 1'b0;
    #(SetupNs);
  endtask

  task automatic stop_cond();
    sdaPullLow = 1'b1;
    half_bit();
    sclClk = 1'b1;
    half_bit();
    sdaPullLow = 1'b0;
    half_bit();
  endtask

  // MSB first, then the acknowledge clock
  task automatic send_byte(input logic [7:0] value, output logic acked);
    for (int i = 7; i >= 0; i--)
    begin
      sdaPullLow = ~value[i];
      half_bit();
      sclClk = 1'b1;
      half_bit();
      sclClk = 1'b0;
      #(SetupNs);
    end
    sdaPullLow = 1'b0;
    half_bit();
    sclClk = 1'b1;
    half_bit();
    acked = ~sdaWire;
    sclClk = 1'b0;
    #(SetupNs);
  endtask

  task automatic write_frame(input logic [7:0] first, input logic [7:0] cmd,
                             input logic [7:0] data, input logic stop,
                             output logic [2:0] acks);
    start_cond();
    send_byte(first, acks[2]);
    send_byte(cmd, acks[1]);
    send_byte(data, acks[0]);
    if (stop)
      stop_cond();
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns

// ******************
// Bench
// ******************
module tb_top;
  localparam logic [6:0] addrTab [4] = '{7'h2d, 7'h2f, 7'h2e, 7'h2c};

  logic       clk_sys;
  logic       resetn;
  logic       sclClk;
  logic       sdaPullLow;
  logic       sdaWire;
  logic       addrSelectHi;
  logic       addrSelectLo;
  logic       powerDownN;
  logic       sdaOut;
  logic       sdaOe;
  logic [9:0] currentOutput;
  logic       shutdownActive;
  logic [2:0] acks;
  int         errors;
  int         comparisons;

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // Open-drain SDA with pull-up
  assign sdaWire = (sdaPullLow || (sdaOe === 1'b1 && sdaOut === 1'b0)) ? 1'b0 : 1'b1;

  smbus_dac_ctrl u_smbus_dac_ctrl
  (
    .clk_sys        (clk_sys),
    .resetn         (resetn),
    .sclClk         (sclClk),
    .sdaIn          (sdaWire),
    .addrSelectHi   (addrSelectHi),
    .addrSelectLo   (addrSelectLo),
    .powerDownN     (powerDownN),
    .sdaOut         (sdaOut),
    .sdaOe          (sdaOe),
    .currentOutput  (currentOutput),
    .shutdownActive (shutdownActive)
  );

  smbus_master_model u_smbus_master_model
  (
    .sclClk     (sclClk),
    .sdaPullLow (sdaPullLow),
    .sdaWire    (sdaWire)
  );

  task automatic check(input string what, input logic [9:0] expected, input logic [9:0] seen);
    comparisons++;
    if (seen !== expected)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic hi, input logic lo);
    @(posedge clk_sys);
    resetn       <= 1'b0;
    addrSelectHi <= hi;
    addrSelectLo <= lo;
    cycles(10);
    resetn <= 1'b1;
    cycles(8);
  endtask

  // Full write, code = {cmd[1:0], data}, junk in cmd[6:2]
  task automatic good_write(input logic [1:0] k, input logic sd, input logic [9:0] code,
                            input logic stop);
    u_smbus_master_model.write_frame({addrTab[k], 1'b0}, {sd, 5'h1f, code[9:8]},
                                     code[7:0], stop, acks);
    cycles(8);
    check("acks", 10'h007, {7'h0, acks});
    check("code", code, currentOutput);
  endtask

  task automatic power_up_values();
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1], k[0]);
      check("power-up code", (k == 3) ? 10'h200 : 10'h000, currentOutput);
      check("shutdown idle", 10'h000, {9'h0, shutdownActive});
    end
  endtask

  task automatic address_select();
    logic [7:0] bad [3];
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1], k[0]);
      good_write(k[1:0], 1'b0, {k[1:0], 8'h5a ^ 8'(k)}, 1'b1);
      bad = '{{addrTab[k ^ 1], 1'b0}, {addrTab[k], 1'b1}, {addrTab[k] ^ 7'h40, 1'b0}};
      for (int b = 0; b < 3; b++)
      begin
        u_smbus_master_model.write_frame(bad[b], 8'h02, 8'hff, 1'b1, acks);
        cycles(8);
        check("nack", 10'h000, {7'h0, acks});
        check("code kept", {k[1:0], 8'h5a ^ 8'(k)}, currentOutput);
      end
    end
  endtask

  task automatic no_stop();
    do_reset(1'b0, 1'b0);
    good_write(2'b00, 1'b0, 10'h3c3, 1'b0);
    good_write(2'b00, 1'b0, 10'h0a1, 1'b0);
    u_smbus_master_model.stop_cond();
  endtask

  task automatic shutdown_paths();
    do_reset(1'b1, 1'b1);
    good_write(2'b11, 1'b0, 10'h1e7, 1'b1);
    powerDownN <= 1'b0;
    cycles(8);
    check("pin shutdown", 10'h001, {9'h0, shutdownActive});
    check("code held", 10'h1e7, currentOutput);
    powerDownN <= 1'b1;
    cycles(8);
    check("pin resume", 10'h000, {9'h0, shutdownActive});
    good_write(2'b11, 1'b1, 10'h2b4, 1'b1);
    check("cmd shutdown", 10'h001, {9'h0, shutdownActive});
    good_write(2'b11, 1'b0, 10'h2b4, 1'b1);
    check("cmd resume", 10'h000, {9'h0, shutdownActive});
  endtask

  initial
  begin
    resetn       = 1'b0;
    addrSelectHi = 1'b0;
    addrSelectLo = 1'b0;
    powerDownN   = 1'b1;
    errors       = 0;
    comparisons  = 0;
    power_up_values();
    address_select();
    no_stop();
    shutdown_paths();
    wrap_up();
  end

  // Hang guard
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
endmodule

/* rtl/link_shift_rx.sv */
`timescale 1ns/1ns

// ****************************************
// Link side byte shifter on the bus clock
// ****************************************
module link_shift_rx
(
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  output logic      [7:0] linkByte
);

  logic [7:0] shift_q;
  logic [7:0] shift_d;

  always_comb
  begin
    shift_d = {shift_q[6:0], sdaIn};
  end

  // Data is sampled on the rising bus clock, MSB first
  always_ff @(posedge sclClk)
  begin
    shift_q <= shift_d;
  end

  assign linkByte = shift_q;

endmodule

/* rtl/smbus_dac_consts.svh */
`ifndef SMBUS_DAC_CONSTS_SVH
`define SMBUS_DAC_CONSTS_SVH

// ****************************************
// Addressing
// ****************************************
`define ADDR_FIXED      5'h0b
`define ADDR_WIDTH      7
`define RW_BIT          0

// ****************************************
// Command byte fields
// ****************************************
`define CMD_POWER_DOWN_N_PIN_BIT    7
`define CMD_MSB_HI      1
`define CMD_MSB_LO      0

// ****************************************
// Code register
// ****************************************
`define CODE_WIDTH      10
`define CODE_MIDSCALE   10'h200
`define CODE_ZERO       10'h000
`define HOLD_RESET      2'h0

// ****************************************
// Timing counts
// ****************************************
`define BYTE_BITS       4'h8
`define INIT_LOAD_CNT   2'h2
`define INIT_DONE_CNT   2'h3

`endif

/* rtl/smbus_dac_ctrl.sv */
// Function
// R1 - The top five bits of the slave address are the fixed pattern 01011.
// R2 - The select pins pick the low address bits: LL 0101101, LH 0101111, HL 0101110, HH 0101100.
// R3 - The device is a receive-only slave updated solely by Write Byte: address, command, data.
// R4 - After START, an address with write bit zero that matches is acknowledged.
// R5 - The command byte's active bits are held at the falling edge of its acknowledge clock.
// R6 - At the final acknowledge's falling edge the data byte and held MSBs load the 10-bit code.
// R7 - No STOP is needed for the update, and the device never waits for one.
// R8 - With both select pins high, the code powers up at mid-scale.
// R9 - With either select pin low, the code powers up at zero.
// R10 - Shutdown holds while the shutdown pin is low or command bit 7 is one.
// R11 - Shutdown leaves the stored code untouched.
// R12 - The master leaves both bus lines high while the bus is idle.
// R13 - A wrong address or a read bit is not acknowledged and the rest of it is ignored.
// R14 - The code MSBs are command bits 1 and 0; other bits except bit 7 are ignored.
`timescale 1ns/1ns
`include "smbus_dac_consts.svh"

module smbus_dac_ctrl
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  input  wire logic       addrSelectHi,
  input  wire logic       addrSelectLo,
  input  wire logic       powerDownN,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic      [9:0] currentOutput,
  output logic            shutdownActive
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic [1:0] addrLowBits(input logic hi, input logic lo);
    logic [1:0] bits;
    bits = 2'h0;
    case ({hi, lo})
      2'b00:   bits = 2'h1;
      2'b01:   bits = 2'h3;
      2'b10:   bits = 2'h2;
      default: bits = 2'h0;
    endcase
    return bits;
  endfunction

  // ****************************************
  // Link domain
  // ****************************************
  logic [7:0] linkByte;

  link_shift_rx u_shift
  (
    .sclClk   (sclClk),
    .sdaIn    (sdaIn),
    .linkByte (linkByte)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sclMeta_q;
  logic [1:0] sdaMeta_q;
  logic [1:0] hiMeta_q;
  logic [1:0] loMeta_q;
  logic [1:0] pdnMeta_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  always_ff @(posedge clk_sys)
  begin
    sclMeta_q <= {sclMeta_q[0], sclClk};
    sdaMeta_q <= {sdaMeta_q[0], sdaIn};
    hiMeta_q  <= {hiMeta_q[0], addrSelectHi};
    loMeta_q  <= {loMeta_q[0], addrSelectLo};
    pdnMeta_q <= {pdnMeta_q[0], powerDownN};
    sclPrev_q <= sclMeta_q[1];
    sdaPrev_q <= sdaMeta_q[1];
  end

  logic sclS;
  logic sdaS;
  logic hiS;
  logic loS;
  logic pdnS;
  logic startEv;
  logic stopEv;
  logic riseEv;
  logic fallEv;
  assign sclS    = sclMeta_q[1];
  assign sdaS    = sdaMeta_q[1];
  assign hiS     = hiMeta_q[1];
  assign loS     = loMeta_q[1];
  assign pdnS    = pdnMeta_q[1];
  assign startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopEv  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign riseEv  = sclS & ~sclPrev_q;
  assign fallEv  = ~sclS & sclPrev_q;

  // ****************************************
  // Receive state machine
  // ****************************************
  smbus_dac_pkg::rx_state_t state_q;
  smbus_dac_pkg::rx_state_t state_d;
  logic [3:0]               bitCnt_q;
  logic [3:0]               bitCnt_d;
  logic [7:0]               lastByte_q;
  logic [7:0]               lastByte_d;
  logic [6:0]               ownAddr_q;
  logic [6:0]               ownAddr_d;
  logic                     sdaOe_q;
  logic                     sdaOe_d;
  logic                     byteDone;
  logic                     holdLoad;
  logic                     codeLoad;
  // Byte is stable in the shifter from its 8th rising edge to the next one
  assign byteDone = fallEv && (bitCnt_q == `BYTE_BITS);
  assign holdLoad = (state_q == smbus_dac_pkg::ST_ACK_CMD) && fallEv;
  assign codeLoad = (state_q == smbus_dac_pkg::ST_ACK_DATA) && fallEv;

  always_comb
  begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    lastByte_d = lastByte_q;
    sdaOe_d    = sdaOe_q;
    ownAddr_d  = {`ADDR_FIXED, addrLowBits(hiS, loS)}; // R1 R2
    if (stopEv)
    begin
      state_d = smbus_dac_pkg::ST_IDLE;
      sdaOe_d = 1'b0;
    end
    else if (startEv)
    begin
      state_d  = smbus_dac_pkg::ST_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d  = 1'b0;
    end
    else
    begin
      case (state_q)
        smbus_dac_pkg::ST_ADDR,
        smbus_dac_pkg::ST_CMD,
        smbus_dac_pkg::ST_DATA:
        begin
          if (riseEv)
          begin
            bitCnt_d = bitCnt_q + 4'h1;
          end
          if (byteDone)
          begin
            lastByte_d = linkByte;
            bitCnt_d   = 4'h0;
            if (state_q == smbus_dac_pkg::ST_ADDR)
            begin
              if ((linkByte[7:1] == ownAddr_q) && !linkByte[`RW_BIT]) // R4
              begin
                state_d = smbus_dac_pkg::ST_ACK_ADDR;
                sdaOe_d = 1'b1;
              end
              else
              begin
                state_d = smbus_dac_pkg::ST_IGNORE; // R13
              end
            end
            else if (state_q == smbus_dac_pkg::ST_CMD)
            begin
              state_d = smbus_dac_pkg::ST_ACK_CMD;
              sdaOe_d = 1'b1;
            end
            else
            begin
              state_d = smbus_dac_pkg::ST_ACK_DATA;
              sdaOe_d = 1'b1;
            end
          end
        end
        smbus_dac_pkg::ST_ACK_ADDR:
        begin
          if (fallEv)
          begin
            state_d = smbus_dac_pkg::ST_CMD;
            sdaOe_d = 1'b0;
          end
        end
        smbus_dac_pkg::ST_ACK_CMD:
        begin
          if (fallEv)
          begin
            state_d = smbus_dac_pkg::ST_DATA;
            sdaOe_d = 1'b0;
          end
        end
        smbus_dac_pkg::ST_ACK_DATA:
        begin
          // Transfer finished; later bytes are left alone until START
          if (fallEv)
          begin
            state_d = smbus_dac_pkg::ST_IGNORE; // R3 R7
            sdaOe_d = 1'b0;
          end
        end
        // Idle and ignored frames never drive the line
        default:
        begin
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_q    <= smbus_dac_pkg::ST_IDLE;
      bitCnt_q   <= 4'h0;
      lastByte_q <= 8'h00;
      ownAddr_q  <= ownAddr_d;
      sdaOe_q    <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      lastByte_q <= lastByte_d;
      ownAddr_q  <= ownAddr_d;
      sdaOe_q    <= sdaOe_d;
    end
  end

  // ****************************************
  // Code, hold and shutdown registers
  // ****************************************
  logic [1:0]                holdMsb_q;
  logic [1:0]                holdMsb_d;
  logic                      cmdShdn_q;
  logic                      cmdShdn_d;
  smbus_dac_pkg::dac_code_t  code_q;
  smbus_dac_pkg::dac_code_t  code_d;
  logic [1:0]                initCnt_q;
  logic [1:0]                initCnt_d;
  logic                      shutdown_q;
  logic                      shutdown_d;

  always_comb
  begin
    holdMsb_d  = holdMsb_q;
    cmdShdn_d  = cmdShdn_q;
    code_d     = code_q;
    initCnt_d  = initCnt_q;
    if (initCnt_q != `INIT_DONE_CNT)
    begin
      initCnt_d = initCnt_q + 2'h1;
    end
    // Power-up value waits for the select pins to pass the synchronisers
    if (initCnt_q == `INIT_LOAD_CNT)
    begin
      code_d = (hiS && loS) ? `CODE_MIDSCALE : `CODE_ZERO; // R8 R9
    end
    if (holdLoad)
    begin
      holdMsb_d = lastByte_q[`CMD_MSB_HI:`CMD_MSB_LO]; // R5 R14
      cmdShdn_d = lastByte_q[`CMD_POWER_DOWN_N_PIN_BIT]; // R10
    end
    // Code loads in shutdown too and is otherwise kept
    if (codeLoad)
    begin
      code_d = {holdMsb_q, lastByte_q}; // R6 R11
    end
    shutdown_d = !pdnS || cmdShdn_q; // R10
  end
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      holdMsb_q  <= `HOLD_RESET;
      cmdShdn_q  <= 1'b0;
      code_q     <= `CODE_ZERO;
      initCnt_q  <= 2'h0;
      shutdown_q <= 1'b0;
    end
    else
    begin
      holdMsb_q  <= holdMsb_d;
      cmdShdn_q  <= cmdShdn_d;
      code_q     <= code_d;
      initCnt_q  <= initCnt_d;
      shutdown_q <= shutdown_d;
    end
  end

  assign sdaOut         = 1'b0;
  assign sdaOe          = sdaOe_q;
  assign currentOutput  = code_q;
  assign shutdownActive = shutdown_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  fixed_addr_bits_a: assert property (ownAddr_q[6:2] == `ADDR_FIXED) // R1
    else $error("fixed address bits wrong");
  addr_pin_map_a: assert property
    (##1 ownAddr_q[1:0] == addrLowBits($past(hiS), $past(loS))) // R2
    else $error("address select mapping wrong");
  addr_ack_match_a: assert property
    ((state_q == smbus_dac_pkg::ST_ACK_ADDR) |->
     (lastByte_q[7:1] == ownAddr_q) && !lastByte_q[0] && sdaOe_q) // R4
    else $error("address acknowledged without match");
  ignore_no_ack_a: assert property
    ((state_q == smbus_dac_pkg::ST_IGNORE) |-> ##1 !sdaOe_q) // R13
    else $error("ack driven in ignored transfer");
  hold_capture_a: assert property
    (holdLoad |=> holdMsb_q == $past(lastByte_q[1:0])) // R5
    else $error("command MSBs not held");
  code_update_a: assert property
    (codeLoad |=> (currentOutput == {$past(holdMsb_q), $past(lastByte_q)})
     && (state_q == smbus_dac_pkg::ST_IGNORE)) // R6
    else $error("code not loaded at final ack");
  code_kept_a: assert property
    ((initCnt_q == `INIT_DONE_CNT) && !codeLoad |=> $stable(currentOutput)) // R11
    else $error("code changed without write");
  powerup_value_a: assert property
    ((initCnt_q == `INIT_LOAD_CNT) |=>
     currentOutput == (($past(hiS) && $past(loS)) ? `CODE_MIDSCALE : `CODE_ZERO)) // R8
    else $error("power-up code wrong");
  pin_shutdown_a: assert property (!pdnS |=> shutdownActive) // R10
    else $error("pin shutdown missed");
  cmd_shutdown_a: assert property
    (holdLoad && lastByte_q[7] |=> ##1 shutdownActive) // R10
    else $error("command shutdown missed");
  write_done_c: cover property (codeLoad);
  addr_miss_c: cover property
    ((state_q == smbus_dac_pkg::ST_ADDR) ##1 (state_q == smbus_dac_pkg::ST_IGNORE));
  cmd_power_down_n_pin_c: cover property (holdLoad && lastByte_q[7]);

endmodule

/* rtl/smbus_dac_pkg.sv */
package smbus_dac_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_CMD      = 3'b011,
    ST_ACK_CMD  = 3'b100,
    ST_DATA     = 3'b101,
    ST_ACK_DATA = 3'b110,
    ST_IGNORE   = 3'b111
  } rx_state_t;

  typedef logic [9:0] dac_code_t;

endpackage
